// File: output_pin_select.sv
// APB register file and pin drivers for three remappable output pins
// Notes on behaviour
// - Each pin has a 6-bit select field
// - Fields reset to zero, meaning default port
// - Codes 1 and 3 route UART transmits
// - Codes 8-10 route SPI three outputs
// - Code 14 routes CAN transmit if present
// - Codes 16-19 route compare outputs one-four
// - Codes 24-26 and 50 route comparators
// - Code 45 routes PWM sync, motor variants
// - Code 47 encoder compare, 49 reference clock (driven low on motor variants)
// - No interlock; any field combination accepted
// - Direction bits gate only output driver
// - Active peripheral output forces driver on
// - Analog pins come up analog after reset
// - Only analog select gates input buffer; a clear bit enables it
// - Register six: pin57 bits 13-8, pin56 5-0
// - Register seven: pin97 bits 13-8 only
`timescale 1ns/10ps
`include "pin_select_defines.svh"
module output_pin_select (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] peri,
  input wire logic has_can,
  input wire logic has_motor,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] input_buffer_en,
  output logic [2:0] digital_in
);
  // Pin order in every 3-bit vector: 0 = pin 56, 1 = pin 57, 2 = pin 97
  pin_select_pkg::sel_t pin56_output_select;
  pin_select_pkg::sel_t pin57_output_select;
  pin_select_pkg::sel_t pin97_output_select;
  logic [2:0] pin_direction_bits;
  logic [2:0] analog_select;
  logic [2:0] port_out;
  logic [2:0] route_data;
  logic [2:0] route_active;
  logic [2:0] next_pin_out;
  logic [2:0] next_pin_oe;
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] next_prdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign mapped = hit(paddr, `OFS_OUTSEL_56_57) | hit(paddr, `OFS_OUTSEL_97) | hit(paddr, `OFS_DIR) |
                  hit(paddr, `OFS_ANALOG) | hit(paddr, `OFS_PORT_OUT) | hit(paddr, `OFS_PIN_IN);
  // Zero wait states keeps the slave trivially predictable
  assign pready = access;
  assign pslverr = access & ~mapped;

  // Fields written independently; no cross-field checks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin56_output_select <= 6'h00;
      pin57_output_select <= 6'h00;
      pin97_output_select <= 6'h00;
    end else if (wr && hit(paddr, `OFS_OUTSEL_56_57)) begin
      pin57_output_select <= pwdata[`PIN57_LSB +: 6];
      pin56_output_select <= pwdata[`PIN56_LSB +: 6];
    end else if (wr && hit(paddr, `OFS_OUTSEL_97)) begin
      pin97_output_select <= pwdata[`PIN97_LSB +: 6];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_direction_bits <= `DIR_RESET;
    end else if (wr && hit(paddr, `OFS_DIR)) begin
      pin_direction_bits <= pwdata[2:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      analog_select <= `ANALOG_RESET;
    end else if (wr && hit(paddr, `OFS_ANALOG)) begin
      analog_select <= pwdata[2:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_out <= 3'h0;
    end else if (wr && hit(paddr, `OFS_PORT_OUT)) begin
      port_out <= pwdata[2:0];
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr, `OFS_OUTSEL_56_57)) begin
      next_prdata = {18'h0_0000, pin57_output_select, 2'h0, pin56_output_select};
    end else if (hit(paddr, `OFS_OUTSEL_97)) begin
      next_prdata = {18'h0_0000, pin97_output_select, 8'h00};
    end else if (hit(paddr, `OFS_DIR)) begin
      next_prdata = {29'h0000_0000, pin_direction_bits};
    end else if (hit(paddr, `OFS_ANALOG)) begin
      next_prdata = {29'h0000_0000, analog_select};
    end else if (hit(paddr, `OFS_PORT_OUT)) begin
      next_prdata = {29'h0000_0000, port_out};
    end else if (hit(paddr, `OFS_PIN_IN)) begin
      next_prdata = {29'h0000_0000, digital_in};
    end
  end

  // Read data registered at the setup cycle so it is stable in the access phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  output_route u_route56 (
    .sel(pin56_output_select),
    .peri(peri),
    .has_can(has_can),
    .has_motor(has_motor),
    .route_data(route_data[0]),
    .route_active(route_active[0])
  );
  output_route u_route57 (
    .sel(pin57_output_select),
    .peri(peri),
    .has_can(has_can),
    .has_motor(has_motor),
    .route_data(route_data[1]),
    .route_active(route_active[1])
  );
  output_route u_route97 (
    .sel(pin97_output_select),
    .peri(peri),
    .has_can(has_can),
    .has_motor(has_motor),
    .route_data(route_data[2]),
    .route_active(route_active[2])
  );

  always_comb begin
    next_pin_out = (route_active & route_data) | (~route_active & port_out);
    // Direction 1 means input; a routed output overrides it
    next_pin_oe = route_active | ~pin_direction_bits;
  end

  // Registered pin drive adds one cycle of latency but removes glitches
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // Input buffer follows the analog select alone, never direction
  assign input_buffer_en = ~analog_select;
  assign digital_in = pin_in & input_buffer_en;

  route_oe_a: assert property (@(posedge mclk) disable iff (rst)
    route_active[0] |=> pin_oe[0]) else $error("routed output not driven");
  dir_only_a: assert property (@(posedge mclk) disable iff (rst)
    (!route_active[1] && pin_direction_bits[1]) |=> !pin_oe[1]) else $error("driver on for input pin");
  null_sel_a: assert property (@(posedge mclk) disable iff (rst)
    (pin97_output_select == 6'h00) |=> (pin_out[2] == $past(port_out[2]))) else $error("null code not default");
  uart_route_a: assert property (@(posedge mclk) disable iff (rst)
    (pin56_output_select == 6'h01) |=> (pin_out[0] == $past(peri[0]))) else $error("uart one not routed");
  cmp4_route_a: assert property (@(posedge mclk) disable iff (rst)
    (pin57_output_select == 6'h32) |=> (pin_out[1] == $past(peri[13]))) else $error("comparator four not routed");
  field_write_a: assert property (@(posedge mclk) disable iff (rst)
    (wr && paddr == 12'h000) |=> (pin57_output_select == $past(pwdata[13:8]))) else $error("field not written");
  unlisted_a: assert property (@(posedge mclk) disable iff (rst)
    (pin56_output_select == 6'h3F) |-> !route_active[0]) else $error("unlisted code routed");
  buffer_en_a: assert property (@(posedge mclk) disable iff (rst)
    analog_select[2] |-> !digital_in[2]) else $error("input seen in analog mode");

  // Absent CAN, PWM sync and encoder codes must fall back to the port latch, like the null code
  sequence can_absent_s;
    (pin97_output_select == `SEL_CAN) && !has_can;
  endsequence
  sequence pwm_present_s;
    (pin57_output_select == `SEL_PWM_SYNC) && has_motor;
  endsequence
  can_gate_a: assert property (@(posedge mclk) disable iff (rst)
    can_absent_s |=> (pin_out[2] == $past(port_out[2]))) else $error("absent can output routed");
  pwm_route_a: assert property (@(posedge mclk) disable iff (rst)
    pwm_present_s |=> (pin_out[1] == $past(peri[14]))) else $error("pwm sync not routed");
  spi_route_a: assert property (@(posedge mclk) disable iff (rst)
    (pin56_output_select == `SEL_SPI_CLOCK) |=> (pin_out[0] == $past(peri[3]))) else $error("spi clock not routed");
  compare_route_a: assert property (@(posedge mclk) disable iff (rst)
    (pin57_output_select == `SEL_COMPARE_FOUR) |=> (pin_out[1] == $past(peri[9]))) else $error("compare four not routed");
  refclk_route_a: assert property (@(posedge mclk) disable iff (rst)
    ((pin56_output_select == `SEL_REFCLK) && !has_motor) |=> (pin_out[0] == $past(peri[15])))
    else $error("reference clock not routed");
  reg7_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (psel && !penable && !pwrite && hit(paddr, `OFS_OUTSEL_97)) |=> ((prdata[7:0] == 8'h00) &&
    (prdata[31:14] == 18'h0_0000))) else $error("unused bits of register seven set");
endmodule : output_pin_select

// File: pin_select_defines.svh
// Offsets, field positions, reset values and select codes of the output pin select block
`ifndef PIN_SELECT_DEFINES_SVH
`define PIN_SELECT_DEFINES_SVH
`define OFS_OUTSEL_56_57 12'h0000
`define OFS_OUTSEL_97 12'h0004
`define OFS_DIR 12'h0008
`define OFS_ANALOG 12'h000C
`define OFS_PORT_OUT 12'h0010
`define OFS_PIN_IN 12'h0014
`define OUTSEL_RESET 16'h0000
`define DIR_RESET 3'h7
`define ANALOG_RESET 3'h7
`define PIN57_LSB 8
`define PIN56_LSB 0
`define PIN97_LSB 8
`define SEL_DEFAULT 6'h00
`define SEL_UART_ONE 6'h01
`define SEL_UART_TWO 6'h03
`define SEL_SPI_DATA 6'h08
`define SEL_SPI_CLOCK 6'h09
`define SEL_SPI_SELECT 6'h0A
`define SEL_CAN 6'h0E
`define SEL_COMPARE_ONE 6'h10
`define SEL_COMPARE_TWO 6'h11
`define SEL_COMPARE_THREE 6'h12
`define SEL_COMPARE_FOUR 6'h13
`define SEL_CMP_ONE 6'h18
`define SEL_CMP_TWO 6'h19
`define SEL_CMP_THREE 6'h1A
`define SEL_PWM_SYNC 6'h2D
`define SEL_ENCODER 6'h2F
`define SEL_REFCLK 6'h31
`define SEL_CMP_FOUR 6'h32
`endif

// File: pin_select_pkg.sv
// Types shared by the output pin select block
package pin_select_pkg;
  typedef logic [5:0] sel_t;
  typedef logic [15:0] peri_t;
endpackage : pin_select_pkg

// File: output_route.sv
// One pin's peripheral output multiplexer
`timescale 1ns/10ps
`include "pin_select_defines.svh"
module output_route (
  input wire pin_select_pkg::sel_t sel,
  input wire pin_select_pkg::peri_t peri,
  input wire has_can,
  input wire has_motor,
  output logic route_data,
  output logic route_active
);
  always_comb begin
    route_data = 1'b0;
    route_active = 1'b1;
    unique case (sel)
      `SEL_UART_ONE: route_data = peri[0];
      `SEL_UART_TWO: route_data = peri[1];
      `SEL_SPI_DATA: route_data = peri[2];
      `SEL_SPI_CLOCK: route_data = peri[3];
      `SEL_SPI_SELECT: route_data = peri[4];
      `SEL_CAN: begin
        route_data = peri[5] & has_can;
        route_active = has_can;
      end
      `SEL_COMPARE_ONE: route_data = peri[6];
      `SEL_COMPARE_TWO: route_data = peri[7];
      `SEL_COMPARE_THREE: route_data = peri[8];
      `SEL_COMPARE_FOUR: route_data = peri[9];
      `SEL_CMP_ONE: route_data = peri[10];
      `SEL_CMP_TWO: route_data = peri[11];
      `SEL_CMP_THREE: route_data = peri[12];
      `SEL_CMP_FOUR: route_data = peri[13];
      `SEL_PWM_SYNC: begin
        route_data = peri[14] & has_motor;
        route_active = has_motor;
      end
      `SEL_ENCODER: begin
        route_data = peri[15] & has_motor;
        route_active = has_motor;
      end
      `SEL_REFCLK: route_data = peri[15] & ~has_motor;
      default: route_active = 1'b0;
    endcase
  end
endmodule : output_route

// File: peripheral_far_side.sv
// Far side model: peripheral output levels and the resolved pin wires
`timescale 1ns/10ps
module peripheral_far_side (
  input wire logic [15:0] next_peri,
  output logic [15:0] peri,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] ext_level,
  output logic [2:0] pin_in
);
  assign peri = next_peri;
  // Undriven pins follow an outside level that changes each step, never the last driven value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : peripheral_far_side

// File: test_output_pin_select.sv
// Self-checking bench for the output pin select block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_output_pin_select;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, has_can = 0, has_motor = 0, pslverr, pready, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r, seed = 32'h0001_5F00;
  logic [15:0] next_peri = 16'h0000, peri;
  logic [2:0] ext = 3'h0, pin_in, pin_out, pin_oe, input_buffer_en, digital_in, dir, pout, ana, eo, ed;
  logic [5:0] sel [3];
  logic [1:0] v;
  int mismatches = 0, num_checks = 0, cycles = 0;
  initial forever #12.5 mclk = ~mclk;
  output_pin_select output_pin_select_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .peri(peri), .has_can(has_can), .has_motor(has_motor), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .input_buffer_en(input_buffer_en), .digital_in(digital_in));
  peripheral_far_side peripheral_far_side_inst (.next_peri(next_peri), .peri(peri), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  task end_of_test;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Idle edge at the end keeps two requests from assigning psel in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask : apb
  task rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
    `CHK(err, ee)
  endtask : rdchk
  // Returns route active and routed level for one select code
  function automatic logic [1:0] route(int s, logic [15:0] p);
    case (s)
      1: return {1'b1, p[0]};
      3: return {1'b1, p[1]};
      8, 9, 10: return {1'b1, p[s - 6]};
      14: return {has_can, p[5]};
      16, 17, 18, 19: return {1'b1, p[s - 10]};
      24, 25, 26: return {1'b1, p[s - 14]};
      50: return {1'b1, p[13]};
      45: return {has_motor, p[14]};
      47: return {has_motor, p[15]};
      49: return {1'b1, p[15] & !has_motor};
      default: return 2'b00;
    endcase
  endfunction : route
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    rdchk(12'h000, 32'h0000_0000, 1'b0);
    rdchk(12'h004, 32'h0000_0000, 1'b0);
    rdchk(12'h008, 32'h0000_0007, 1'b0);
    rdchk(12'h00C, 32'h0000_0007, 1'b0);
    `CHK(pin_oe, 3'h0)
    `CHK(input_buffer_en, 3'h0)
    $display("Test reset done");
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    rdchk(12'h000, 32'h0000_3F3F, 1'b0);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    rdchk(12'h004, 32'h0000_3F00, 1'b0);
    apb(1'b1, 12'h018, 32'h0000_0005);
    rdchk(12'h018, 32'h0000_0000, 1'b1);
    $display("Test fields done");
    for (int i = 0; i < 192; i++) begin
      r = xorshift();
      sel[0] = i[5:0];
      sel[1] = (i < 64) ? i[5:0] : r[5:0];
      sel[2] = (i < 64) ? i[5:0] : r[11:6];
      dir = r[14:12];
      pout = r[17:15];
      ana = r[20:18];
      apb(1'b1, 12'h000, {18'h0, sel[1], 2'h0, sel[0]});
      apb(1'b1, 12'h004, {18'h0, sel[2], 8'h00});
      apb(1'b1, 12'h008, {29'h0, dir});
      apb(1'b1, 12'h010, {29'h0, pout});
      apb(1'b1, 12'h00C, {29'h0, ana});
      r = xorshift();
      next_peri <= r[15:0];
      ext <= r[18:16];
      has_can <= r[19];
      has_motor <= r[20];
      repeat (2) @(posedge mclk);
      #1;
      for (int k = 0; k < 3; k++) begin
        v = route(sel[k], next_peri);
        eo[k] = v[1] | !dir[k];
        ed[k] = v[1] ? v[0] : pout[k];
      end
      `CHK(pin_oe, eo)
      `CHK(pin_out, ed)
      `CHK(input_buffer_en, ~ana)
      `CHK(digital_in, ((eo & ed) | (~eo & ext)) & ~ana)
      rdchk(12'h010, {29'h0, pout}, 1'b0);
      rdchk(12'h014, {29'h0, ((eo & ed) | (~eo & ext)) & ~ana}, 1'b0);
      @(posedge mclk);
    end
    $display("Test routing done");
    end_of_test();
  end
endmodule : test_output_pin_select
